// ---- irtl_cfg.svh ----
`ifndef IRTL_CFG_SVH
`define IRTL_CFG_SVH

// Register byte addresses.
`define IRTL_ADDR_CTRL     8'h00
`define IRTL_ADDR_CARRIER  8'h04
`define IRTL_ADDR_TXDATA   8'h08
`define IRTL_ADDR_STATUS   8'h0c
`define IRTL_ADDR_LDUR     8'h10
`define IRTL_ADDR_LCARR    8'h14

// Control field positions.
`define IRTL_CTRL_TXEN     0
`define IRTL_CTRL_SRC_LO   1
`define IRTL_CTRL_SRC_HI   2
`define IRTL_CTRL_MOD      3
`define IRTL_CTRL_PBIT     4
`define IRTL_CTRL_LEN      5
`define IRTL_CTRL_LMOD     6
`define IRTL_CTRL_W        7

// Descriptor and status fields.
`define IRTL_DESC_STATE    15
`define IRTL_STAT_UNDER    3
`define IRTL_STAT_LEVEL    8

// Reset values.
`define IRTL_CTRL_RST      7'h00
`define IRTL_CARRIER_RST   16'h0149

// Timing.
`define IRTL_CLK_PERIOD_NS 40
`define IRTL_TICK_NS       1000
`define IRTL_TICK_CYC      (`IRTL_TICK_NS / `IRTL_CLK_PERIOD_NS)
`define IRTL_CARR_MIN_KHZ  10
`define IRTL_CARR_MAX_KHZ  500
`define IRTL_CARR_MAX_CYC  (1000000 / (`IRTL_CARR_MIN_KHZ * `IRTL_CLK_PERIOD_NS))
`define IRTL_CARR_MIN_CYC  ((1000000 + `IRTL_CARR_MAX_KHZ * `IRTL_CLK_PERIOD_NS - 1) \
                            / (`IRTL_CARR_MAX_KHZ * `IRTL_CLK_PERIOD_NS))
`define IRTL_DUR_MAX       15'h7fff

`endif

// ---- irtl_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module irtl_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16,
    localparam int AW   = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic    clk_i,
    input  wire logic    rst_i,
    // Queue ports
    irtl_fifo_if.fifo    port,
    output logic [AW:0]  level_o
);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("irtl_fifo depth must be a power of two of at least two");
    end

    logic [W-1:0] mem_reg [DEPTH];
    logic [AW:0]  wr_ptr_reg;
    logic [AW:0]  rd_ptr_reg;

    wire logic full_w  = (wr_ptr_reg ^ rd_ptr_reg) == {1'b1, {AW{1'b0}}};
    wire logic empty_w = wr_ptr_reg == rd_ptr_reg;
    wire logic push_w  = port.wr_valid & ~full_w;
    wire logic pop_w   = port.rd_ready & ~empty_w;

    assign port.wr_ready = ~full_w;
    assign port.rd_valid = ~empty_w;
    assign port.rd_data  = mem_reg[rd_ptr_reg[AW-1:0]];
    assign level_o       = wr_ptr_reg - rd_ptr_reg;

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_i) begin
            if (push_w && wr_ptr_reg[AW-1:0] == AW'(i)) begin
                mem_reg[i] <= port.wr_data;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push_w) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop_w) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule // irtl_fifo
`default_nettype wire

// ---- irtl_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface irtl_fifo_if #(parameter int W = 16) ();
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;
    modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
    modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// ---- irtl_ir_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module irtl_ir_model (
    // Clock
    input  wire logic clk_i,
    // Emitter side
    input  wire logic infrared_transmit_path_i,
    // Receiver front end
    output var logic  ir_rx_o
);
    int lit_cyc = 0;

    // The emitter only counts lit cycles; it cannot push back on the block.
    always @(posedge clk_i) begin
        if (infrared_transmit_path_i === 1'b1) begin
            lit_cyc <= lit_cyc + 1;
        end
    end

    // The receiver output idles dark, so a stale level never looks like light.
    initial ir_rx_o = 1'b0;

    // Plain light for n clocks, then dark again.
    task automatic present(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            ir_rx_o <= 1'b1;
        end
        @(posedge clk_i);
        ir_rx_o <= 1'b0;
    endtask

    // Square carrier of period p clocks for k periods, then dark.
    task automatic carrier(input int p, input int k);
        for (int i = 0; i < p * k; i++) begin
            @(posedge clk_i);
            ir_rx_o <= ((i % p) < (p / 2));
        end
        @(posedge clk_i);
        ir_rx_o <= 1'b0;
    endtask
endmodule // irtl_ir_model
`default_nettype wire

// ---- irtl_pkg.sv ----
`default_nettype none
package irtl_pkg;
    typedef enum logic [1:0] {
        SRC_FIFO,
        SRC_BIT,
        SRC_UART
    } irtl_src_t;
    typedef enum logic {
        TX_IDLE,
        TX_PLAY
    } irtl_tx_state_t;
endpackage
`default_nettype wire

// ---- irtl_top.sv ----
// What this block does
// [RQ1] Transmit output is carrier-modulated or plain on/off, chosen by a control bit.
// [RQ2] In modulated mode the carrier is gated into every on interval.
// [RQ3] Waveform source is queued descriptors, a programmable bit, or the UART transmitter.
// [RQ4] A descriptor holds an on/off state for exactly 1 to 32767 microseconds.
// [RQ5] Descriptors play from the FIFO in order, back to back without gaps.
// [RQ6] Firmware must keep the FIFO fed so it never runs empty mid-transmission.
// [RQ7] Learning detects both modulated and unmodulated incoming signals.
// [RQ8] Incoming carrier period is measured for carriers from 10 kHz to 500 kHz.
// [RQ9] Each present and absent interval of the input is timed and reported.
// [RQ10] Learning durations use the free-running microsecond tick us_tick; transmit times descriptors with its own phase counter sub_reg instead.
`include "irtl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module irtl_top #(
    parameter int FIFO_DEPTH = 16,
    parameter int LOSS_CYC   = 2 * `IRTL_CARR_MAX_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Infrared and UART pins
    input  wire logic        uart_txd_i,
    input  wire logic        ir_rx_i,
    output logic             infrared_transmit_path_o
);
    localparam int TC = `IRTL_TICK_CYC;
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    if (TC < 2 || TC > 255 || LOSS_CYC <= `IRTL_CARR_MAX_CYC || LOSS_CYC > 8191) begin : g_bad
        $error("irtl_top timing parameters out of range");
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    irtl_fifo_if #(.W(16)) fq ();
    logic [LW-1:0] fifo_level;

    irtl_fifo #(
        .W     (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .port    (fq.fifo),
        .level_o (fifo_level)
    );

    logic                     ack_reg;
    logic [31:0]              dat_reg;
    logic [`IRTL_CTRL_W-1:0]  ctrl_reg;
    logic [15:0]              half_reg;
    logic [7:0]               div_reg;
    irtl_pkg::irtl_tx_state_t tx_state_reg;
    logic                     tx_lvl_reg;
    logic [14:0]              rem_reg;
    logic [7:0]               sub_reg;
    logic                     under_reg;
    logic [15:0]              carr_cnt_reg;
    logic                     carr_reg;
    logic                     infrared_transmit_path_reg;
    logic                     rx_d_reg;
    logic [15:0]              per_reg;
    logic [12:0]              loss_reg;
    logic [15:0]              lcar_reg;
    logic                     lcar_ok_reg;
    logic                     pres_reg;
    logic [14:0]              ldur_cnt_reg;
    logic [15:0]              ldur_reg;
    logic                     lvalid_reg;
    logic                     lovf_reg;

    // Register bus decode. A descriptor write waits for room, which stalls the master.
    wire logic sel_ctrl  = adr_i == `IRTL_ADDR_CTRL;
    wire logic sel_carr  = adr_i == `IRTL_ADDR_CARRIER;
    wire logic sel_txd   = adr_i == `IRTL_ADDR_TXDATA;
    wire logic sel_stat  = adr_i == `IRTL_ADDR_STATUS;
    wire logic sel_ldur  = adr_i == `IRTL_ADDR_LDUR;
    wire logic sel_lcar  = adr_i == `IRTL_ADDR_LCARR;
    wire logic req_w     = cyc_i & stb_i & ~ack_reg;
    wire logic push_w    = req_w & we_i & sel_txd & (&sel_i[1:0]);
    wire logic take_w    = req_w & (~push_w | fq.wr_ready);
    wire logic wr_w      = take_w & we_i;
    wire logic rd_w      = take_w & ~we_i;
    wire logic pop_ldur  = rd_w & sel_ldur;
    wire logic clr_under = wr_w & sel_stat & sel_i[0] & dat_i[`IRTL_STAT_UNDER];

    assign fq.wr_valid = push_w;
    assign fq.wr_data  = dat_i[15:0];

    wire logic [31:0] stat_w = (32'(fifo_level) << `IRTL_STAT_LEVEL)
                             | {26'h0, lovf_reg, lvalid_reg, under_reg,
                                tx_state_reg == irtl_pkg::TX_PLAY, ~fq.wr_ready, ~fq.rd_valid};
    wire logic [31:0] rdata_w = sel_ctrl ? {25'h0, ctrl_reg}
                              : sel_carr ? {16'h0, half_reg}
                              : sel_stat ? stat_w
                              : sel_ldur ? {16'h0, ldur_reg}
                              : sel_lcar ? {15'h0, lcar_ok_reg, lcar_reg}
                              : 32'h0;

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= take_w;
            if (rd_w) begin
                dat_reg <= rdata_w;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `IRTL_CTRL_RST;
            half_reg <= `IRTL_CARRIER_RST;
        end else begin
            if (wr_w && sel_ctrl && sel_i[0]) begin
                ctrl_reg <= dat_i[`IRTL_CTRL_W-1:0];
            end
            if (wr_w && sel_carr && sel_i[0]) begin
                half_reg[7:0] <= dat_i[7:0];
            end
            if (wr_w && sel_carr && sel_i[1]) begin
                half_reg[15:8] <= dat_i[15:8];
            end
        end
    end

    wire logic tx_en  = ctrl_reg[`IRTL_CTRL_TXEN];
    wire logic mod_en = ctrl_reg[`IRTL_CTRL_MOD];
    wire logic pbit   = ctrl_reg[`IRTL_CTRL_PBIT];
    wire logic len    = ctrl_reg[`IRTL_CTRL_LEN];
    wire logic lmod   = ctrl_reg[`IRTL_CTRL_LMOD];
    wire irtl_pkg::irtl_src_t src_w =
        irtl_pkg::irtl_src_t'(ctrl_reg[`IRTL_CTRL_SRC_HI:`IRTL_CTRL_SRC_LO]);

    // One microsecond tick for the learning timers.
    wire logic us_tick = div_reg == 8'(TC - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i || us_tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    sequence s_tick_quiet;
        !us_tick [*8];
    endsequence
    a_tick_period: assert property (us_tick |=> s_tick_quiet ##17 us_tick) // see [RQ10]
        else $error("microsecond tick period wrong");

    // Descriptor playback. The engine keeps its own phase so each descriptor lasts
    // exactly its count of whole microseconds, one for a zero count, whatever the free tick phase is.
    wire logic playing = tx_state_reg == irtl_pkg::TX_PLAY;
    wire logic tx_src  = tx_en & (src_w == irtl_pkg::SRC_FIFO);
    wire logic sub_end = sub_reg == 8'(TC - 1); // see [RQ10]
    wire logic fin_w   = playing & sub_end & (rem_reg == 15'h0001); // see [RQ4]
    wire logic load_w  = tx_src & fq.rd_valid & (~playing | fin_w); // see [RQ5]
    wire logic [14:0] dur_w = fq.rd_data[14:0];

    assign fq.rd_ready = load_w;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state_reg <= irtl_pkg::TX_IDLE;
            tx_lvl_reg   <= 1'b0;
            rem_reg      <= 15'h0000;
            sub_reg      <= 8'h00;
        end else if (load_w) begin
            tx_state_reg <= irtl_pkg::TX_PLAY;
            tx_lvl_reg   <= fq.rd_data[`IRTL_DESC_STATE]; // see [RQ4]
            rem_reg      <= (dur_w == 15'h0000) ? 15'h0001 : dur_w;
            sub_reg      <= 8'h00;
        end else if (fin_w || (playing && !tx_src)) begin
            tx_state_reg <= irtl_pkg::TX_IDLE;
            tx_lvl_reg   <= 1'b0;
        end else if (playing) begin
            sub_reg <= sub_end ? 8'h00 : sub_reg + 8'h01;
            if (sub_end) begin
                rem_reg <= rem_reg - 15'h0001; // see [RQ4]
            end
        end
    end

    // Running dry at the end of a descriptor is flagged; a new event beats the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            under_reg <= 1'b0;
        end else if (fin_w && tx_src && !fq.rd_valid) begin
            under_reg <= 1'b1; // see [RQ6]
        end else if (clr_under) begin
            under_reg <= 1'b0;
        end
    end

    a_rem_step: assert property ((playing && tx_src && sub_end && rem_reg > 15'h0001) // see [RQ4]
        |=> rem_reg == $past(rem_reg) - 15'h0001)
        else $error("descriptor countdown slipped");
    a_level_held: assert property ((playing && tx_src && !load_w && !fin_w) // see [RQ4]
        |=> playing && tx_lvl_reg == $past(tx_lvl_reg))
        else $error("descriptor state changed early");
    a_no_gap: assert property ((fin_w && tx_src && fq.rd_valid) // see [RQ5]
        |-> load_w ##1 playing)
        else $error("gap between descriptors");

    // Envelope from the selected source; the UART line is taken as on while low.
    wire logic env_w = tx_en & ( (src_w == irtl_pkg::SRC_FIFO) ? (playing & tx_lvl_reg)
                               : (src_w == irtl_pkg::SRC_BIT)  ? pbit
                               : (src_w == irtl_pkg::SRC_UART) ? ~uart_txd_i
                               : 1'b0); // see [RQ3]

    // The carrier restarts high at each on interval so every burst begins with a full half cycle.
    wire logic carr_wrap = ({1'b0, carr_cnt_reg} + 17'h00001) >= {1'b0, half_reg};

    always_ff @(posedge clk_i) begin
        if (rst_i || !env_w) begin
            carr_cnt_reg <= 16'h0000;
            carr_reg     <= 1'b1;
        end else if (carr_wrap) begin
            carr_cnt_reg <= 16'h0000;
            carr_reg     <= ~carr_reg; // see [RQ2]
        end else begin
            carr_cnt_reg <= carr_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            infrared_transmit_path_reg <= 1'b0;
        end else begin
            infrared_transmit_path_reg <= env_w & (mod_en ? carr_reg : 1'b1); // see [RQ1]
        end
    end

    assign infrared_transmit_path_o = infrared_transmit_path_reg;

    a_plain_on: assert property ((env_w && !mod_en) |=> infrared_transmit_path_o) // see [RQ1]
        else $error("plain output not on");
    a_dark_off: assert property (!env_w |=> !infrared_transmit_path_o) // see [RQ2]
        else $error("output on outside an on interval");
    a_carrier_flip: assert property ((env_w && mod_en && carr_wrap) // see [RQ2]
        ##1 (env_w && mod_en) |=> infrared_transmit_path_o != $past(infrared_transmit_path_o))
        else $error("carrier did not toggle");
    a_src_bit: assert property ((tx_en && src_w == irtl_pkg::SRC_BIT && !mod_en) // see [RQ3]
        |=> infrared_transmit_path_o == $past(pbit))
        else $error("programmable bit not followed");
    a_src_uart: assert property ((tx_en && src_w == irtl_pkg::SRC_UART && !mod_en) // see [RQ3]
        |=> infrared_transmit_path_o == !$past(uart_txd_i))
        else $error("uart source not followed");

    // Learning: carrier period between rising edges, presence, interval timing.
    wire logic rise_w   = ir_rx_i & ~rx_d_reg;
    wire logic per_ok   = per_reg >= 16'(`IRTL_CARR_MIN_CYC) && per_reg <= 16'(`IRTL_CARR_MAX_CYC);
    wire logic pres_mod = loss_reg < 13'(LOSS_CYC);
    wire logic pres_w   = lmod ? pres_mod : ir_rx_i; // see [RQ7]
    wire logic edge_w   = len & (pres_w != pres_reg);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_d_reg    <= 1'b0;
            per_reg     <= 16'hffff;
            loss_reg    <= 13'(LOSS_CYC);
            lcar_reg    <= 16'h0000;
            lcar_ok_reg <= 1'b0;
        end else begin
            rx_d_reg <= ir_rx_i;
            if (rise_w) begin
                per_reg  <= 16'h0001;
                loss_reg <= 13'h0000;
                if (per_ok) begin
                    lcar_reg    <= per_reg; // see [RQ8]
                    lcar_ok_reg <= 1'b1;
                end
            end else begin
                per_reg  <= (per_reg == 16'hffff) ? per_reg : per_reg + 16'h0001;
                loss_reg <= pres_mod ? loss_reg + 13'h0001 : loss_reg;
            end
        end
    end

    // In modulated mode presence ends one loss window after the last edge, so each
    // present interval reads long and the following absent one short by that window.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pres_reg     <= 1'b0;
            ldur_cnt_reg <= 15'h0000;
            ldur_reg     <= 16'h0000;
            lvalid_reg   <= 1'b0;
            lovf_reg     <= 1'b0;
        end else begin
            if (!len || edge_w) begin
                pres_reg     <= pres_w;
                ldur_cnt_reg <= 15'h0000;
            end else if (us_tick && ldur_cnt_reg != `IRTL_DUR_MAX) begin
                ldur_cnt_reg <= ldur_cnt_reg + 15'h0001; // see [RQ10]
            end
            if (edge_w) begin
                ldur_reg   <= {pres_reg, ldur_cnt_reg}; // see [RQ9]
                lvalid_reg <= 1'b1;
                if (lvalid_reg && !pop_ldur) begin
                    lovf_reg <= 1'b1;
                end
            end else if (pop_ldur) begin
                lvalid_reg <= 1'b0;
            end
            if (wr_w && sel_stat && sel_i[0] && dat_i[5]) begin
                lovf_reg <= edge_w & lvalid_reg & ~pop_ldur;
            end
        end
    end

    a_carr_meas: assert property ((rise_w && per_ok) // see [RQ8]
        |=> lcar_ok_reg && lcar_reg == $past(per_reg))
        else $error("carrier period not captured");
    a_mod_present: assert property (rise_w |=> pres_mod) // see [RQ7]
        else $error("modulated input not seen as present");
    a_interval_log: assert property (edge_w // see [RQ9]
        |=> lvalid_reg && ldur_reg[15] == $past(pres_reg) && ldur_reg[14:0] == $past(ldur_cnt_reg))
        else $error("interval not reported");
endmodule // irtl_top
`default_nettype wire

// ---- irtl_top_test.sv ----
`include "irtl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end
module irtl_top_test;
    localparam int TK   = `IRTL_TICK_CYC;
    localparam int LOSS = 2600;
    logic        clk_i;
    logic        rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        uart_txd_i;
    logic        ir_rx_i;
    logic        infrared_transmit_path_o;
    logic [31:0] q;
    int          n_errors = 0;
    int          compares = 0;
    int          n;
    int          m;

    irtl_top #(.FIFO_DEPTH(16), .LOSS_CYC(LOSS)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .uart_txd_i(uart_txd_i), .ir_rx_i(ir_rx_i), .infrared_transmit_path_o(infrared_transmit_path_o));
    irtl_ir_model ir_model (.clk_i(clk_i), .infrared_transmit_path_i(infrared_transmit_path_o), .ir_rx_o(ir_rx_i));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic close_out;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One classic cycle; the answer is awaited, never assumed.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 2000);
        if (k >= 2000) n_errors++;
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wait_tx(input logic v);
        int k;
        k = 0;
        while (infrared_transmit_path_o !== v && k < 5000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 5000) n_errors++;
    endtask

    task automatic run_len(input logic v, output int len);
        len = 0;
        while (infrared_transmit_path_o === v && len < 20000) begin
            @(posedge clk_i);
            len++;
        end
    endtask

    task automatic stop_tx;
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h0);
        wb(1'b1, `IRTL_ADDR_STATUS, 32'h8);
    endtask

    task automatic t_reset;
        wb(1'b0, `IRTL_ADDR_CTRL, 32'h0);
        `CHK(q, 32'h0)
        wb(1'b0, `IRTL_ADDR_CARRIER, 32'h0);
        `CHK(q[15:0], 16'h0149)
        wb(1'b1, 8'h3c, 32'hffff_ffff);
        wb(1'b0, 8'h3c, 32'h0);
        `CHK(q, 32'h0)
    endtask

    // Durations and states must follow the queue order with no gap.
    task automatic t_order;
        wb(1'b1, `IRTL_ADDR_TXDATA, 32'h8002);
        wb(1'b1, `IRTL_ADDR_TXDATA, 32'h0001);
        wb(1'b1, `IRTL_ADDR_TXDATA, 32'h8003);
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h01);
        wait_tx(1'b1);
        run_len(1'b1, n);
        `CHK(n, 2 * TK)
        run_len(1'b0, n);
        `CHK(n, TK)
        run_len(1'b1, n);
        `CHK(n, 3 * TK)
        wb(1'b0, `IRTL_ADDR_STATUS, 32'h0);
        `CHK(q[3:2], 2'b10)
        `CHK(infrared_transmit_path_o, 1'b0)
        stop_tx();
    endtask

    task automatic t_full;
        for (int i = 0; i < 16; i++) wb(1'b1, `IRTL_ADDR_TXDATA, 32'h8001);
        wb(1'b0, `IRTL_ADDR_STATUS, 32'h0);
        `CHK(q & 32'h1f03, 32'h1002)
        m = ir_model.lit_cyc;
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h01);
        wait_tx(1'b1);
        run_len(1'b1, n);
        `CHK(n, 16 * TK)
        `CHK(ir_model.lit_cyc - m, 16 * TK)
        wb(1'b0, `IRTL_ADDR_STATUS, 32'h0);
        `CHK(q[0], 1'b1)
        stop_tx();
    endtask

    task automatic t_mod;
        wb(1'b1, `IRTL_ADDR_CARRIER, 32'h4);
        wb(1'b1, `IRTL_ADDR_TXDATA, 32'h8002);
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h09);
        wait_tx(1'b1);
        run_len(1'b1, n);
        `CHK(n, 4)
        run_len(1'b0, n);
        `CHK(n, 4)
        run_len(1'b1, n);
        `CHK(n, 4)
        stop_tx();
    endtask

    task automatic t_bit_uart;
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h13);
        repeat (3) @(posedge clk_i);
        `CHK(infrared_transmit_path_o, 1'b1)
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h03);
        repeat (3) @(posedge clk_i);
        `CHK(infrared_transmit_path_o, 1'b0)
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h1b);
        wait_tx(1'b1);
        run_len(1'b1, n);
        `CHK(n, 4)
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h05);
        uart_txd_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK(infrared_transmit_path_o, 1'b1)
        uart_txd_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK(infrared_transmit_path_o, 1'b0)
        // With the source field set to its unused code, neither the bit nor the line may light.
        uart_txd_i <= 1'b0;
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h17);
        repeat (3) @(posedge clk_i);
        `CHK(infrared_transmit_path_o, 1'b0)
        uart_txd_i <= 1'b1;
        stop_tx();
    endtask

    // Interval lengths allow one tick of quantisation either way.
    task automatic t_learn;
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h20);
        ir_model.present(10 * TK);
        repeat (5 * TK) @(posedge clk_i);
        fork
            ir_model.present(10 * TK);
        join_none
        repeat (10) @(posedge clk_i);
        wb(1'b0, `IRTL_ADDR_LDUR, 32'h0);
        `CHK(q[15], 1'b0)
        `CHK(q[14:0] >= 15'h4 && q[14:0] <= 15'h6, 1'b1)
        repeat (10 * TK) @(posedge clk_i);
        wb(1'b0, `IRTL_ADDR_STATUS, 32'h0);
        `CHK(q[4], 1'b1)
        `CHK(q[5], 1'b1)
        wb(1'b0, `IRTL_ADDR_LDUR, 32'h0);
        `CHK(q[15], 1'b1)
        `CHK(q[14:0] >= 15'h9 && q[14:0] <= 15'hb, 1'b1)
        wb(1'b1, `IRTL_ADDR_STATUS, 32'h20);
        wb(1'b0, `IRTL_ADDR_STATUS, 32'h0);
        `CHK(q[4], 1'b0)
        `CHK(q[5], 1'b0)
    endtask

    // Both ends of the carrier range.
    task automatic t_carr;
        int per [2] = '{50, 2500};
        wb(1'b1, `IRTL_ADDR_CTRL, 32'h60);
        foreach (per[i]) begin
            ir_model.carrier(per[i], 4);
            repeat (LOSS + 20) @(posedge clk_i);
            wb(1'b0, `IRTL_ADDR_LCARR, 32'h0);
            `CHK(q[16:0], {1'b1, 16'(per[i])})
            wb(1'b0, `IRTL_ADDR_STATUS, 32'h0);
            `CHK(q[4], 1'b1)
            wb(1'b0, `IRTL_ADDR_LDUR, 32'h0);
        end
    endtask

    initial begin
        rst_i      = 1'b1;
        cyc_i      = 1'b0;
        stb_i      = 1'b0;
        we_i       = 1'b0;
        adr_i      = 8'h00;
        sel_i      = 4'hf;
        dat_i      = 32'h0;
        uart_txd_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_order();
        t_full();
        t_mod();
        t_bit_uart();
        t_learn();
        t_carr();
        close_out();
    end

    // The tests need about 20000 cycles; this leaves ample margin.
    initial begin
        #4000000;
        n_errors++;
        close_out();
    end
endmodule // irtl_top_test
`default_nettype wire
